// ==== pkg/rtcis_map.svh ====
`ifndef RTCIS_MAP_SVH
`define RTCIS_MAP_SVH

// ----------------------------------------
// bus addressing
// ----------------------------------------
`define RTCIS_SLAVE_ADDR 7'h51
`define RTCIS_WORD_BITS 4
`define RTCIS_BYTE_BITS 8
`define RTCIS_IDLE_BYTE 8'hFF

// ----------------------------------------
// write buffer
// ----------------------------------------
`define RTCIS_FIFO_WIDTH 12
`define RTCIS_FIFO_DEPTH 8

// ----------------------------------------
// watchdog timing
// ----------------------------------------
`define RTCIS_CLK_HZ 25000000
`define RTCIS_WDOG_TIME_S 1
`define RTCIS_WDOG_CYCLES (`RTCIS_CLK_HZ * `RTCIS_WDOG_TIME_S)

`endif

// ==== pkg/rtcis_pkg.sv ====
package rtcis_pkg;

    // ----------------------------------------
    // link state machine
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_WRITE = 3'h2,
        ST_ACK   = 3'h3,
        ST_SEND  = 3'h4,
        ST_MACK  = 3'h5
    } rtcis_state_t;

endpackage

// ==== rtl/rtcis_top.sv ====
`timescale 1ns/10ps
// Functional notes
// - one bit per clock, data steady while high
// - data falling with clock high starts
// - data rising with clock high stops
// - eight-bit bytes, each followed by acknowledge
// - slave receiver pulls data low during ninth; here a data byte meeting a full write buffer gets no-ack
// - on master no-ack, release data line
// - first byte is address; answer only match
// - slave only; clock input; data bidirectional
// - word address uses low four bits only
// - time counters frozen during access
// - stalled access aborted, idle, counting resumes
// - start or stop stops the watchdog
// - watchdog expires between one and two seconds
// - each expiry costs exactly one second
`include "rtcis_map.svh"

// ----------------------------------------
// dual-clock write buffer
// ----------------------------------------
module rtcis_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // fill side
    input wire logic wclk_i,
    input wire logic wrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    input wire logic rclk_i,
    input wire logic rrst_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [2:0][AW:0] peer_sy;
        logic [AW:0] peer;
    } rtcis_fside_t;

    rtcis_fside_t w, next_w, r, next_r;
    logic full;
    logic empty;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // a pointer change counts once stages two and three agree
    function automatic logic [AW:0] settle_ptr(input logic [2:0][AW:0] sy,
                                               input logic [AW:0] cur);
        return (sy[2] == sy[1]) ? sy[2] : cur;
    endfunction

    assign full = (w.gray == {~w.peer[AW:AW-1], w.peer[AW-2:0]});
    assign empty = (r.gray == r.peer);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = w.mem[r.bin[AW-1:0]];

    always_comb begin
        next_w = w;
        next_w.peer_sy = {w.peer_sy[1:0], r.gray};
        next_w.peer = settle_ptr(w.peer_sy, w.peer);
        if (in_valid_i && !full) begin
            next_w.mem[w.bin[AW-1:0]] = in_data_i;
            next_w.bin = w.bin + 1'b1;
            next_w.gray = to_gray(next_w.bin);
        end
        if (wrst_i) begin
            next_w = '0;
        end
    end

    always_ff @(posedge wclk_i) begin
        w <= next_w;
    end

    always_comb begin
        next_r = r;
        next_r.mem = '0;
        next_r.peer_sy = {r.peer_sy[1:0], w.gray};
        next_r.peer = settle_ptr(r.peer_sy, r.peer);
        if (out_ready_i && !empty) begin
            next_r.bin = r.bin + 1'b1;
            next_r.gray = to_gray(next_r.bin);
        end
        if (rrst_i) begin
            next_r = '0;
        end
    end

    always_ff @(posedge rclk_i) begin
        r <= next_r;
    end
endmodule

// ----------------------------------------
// serial slave port with watchdog
// ----------------------------------------
module rtcis_top #(
    parameter int WDOG_CYCLES = `RTCIS_WDOG_CYCLES
) (
    // system clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // serial link
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // register writes
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [3:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    // register reads
    output logic rd_strobe_o,
    output logic [3:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    // time keeping control
    output logic freeze_o,
    output logic wdog_abort_o
);
    localparam int CW = $clog2(WDOG_CYCLES + 1);

    typedef struct packed {
        logic [2:0] scl_sy;
        logic scl;
        logic [2:0] sda_sy;
        logic sda;
        logic [2:0] abt_sy;
        logic abt;
        logic [2:0] ack_sy;
        logic ack;
        rtcis_pkg::rtcis_state_t state;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic do_ack;
        logic ack_ph;
        logic mack;
        logic [3:0] ptr;
        logic busy;
        logic oe;
        logic req;
        logic [3:0] req_addr;
        logic [7:0] tx_buf;
        logic [3:0] tx_addr;
        logic tx_valid;
        logic push;
        logic [11:0] push_data;
    } rtcis_link_t;

    typedef struct packed {
        logic [2:0] req_sy;
        logic req;
        logic ack;
        logic strobe;
        logic [3:0] raddr;
        logic [7:0] rbyte;
        logic [2:0] bsy_sy;
        logic busy;
        logic abort;
        logic pulse;
        logic freeze;
        logic [CW-1:0] cnt;
    } rtcis_sys_t;

    rtcis_link_t lk, next_lk;
    rtcis_sys_t sy, next_sy;
    logic [2:0] link_rst_sy;
    logic link_rst;
    logic fifo_ready;
    logic [11:0] fifo_out;
    logic scl_rise, scl_fall, start, stop, buf_hit, do_load;
    logic [7:0] rx_byte, tx_byte;

    // a change from the other side counts once stages two and three agree
    function automatic logic settle(input logic [2:0] s, input logic cur);
        return (s[2] == s[1]) ? s[2] : cur;
    endfunction

    // link reset follows the system reset into the link domain
    always_ff @(posedge link_clk_i) begin
        link_rst_sy <= {link_rst_sy[1:0], rst_i};
    end
    assign link_rst = link_rst_sy[2];

    // ----------------------------------------
    // link domain
    // ----------------------------------------
    always_comb begin
        next_lk = lk;
        next_lk.push = 1'b0;
        next_lk.scl_sy = {lk.scl_sy[1:0], scl_i};
        next_lk.sda_sy = {lk.sda_sy[1:0], sda_i};
        next_lk.abt_sy = {lk.abt_sy[1:0], sy.abort};
        next_lk.ack_sy = {lk.ack_sy[1:0], sy.ack};
        next_lk.scl = settle(lk.scl_sy, lk.scl);
        next_lk.sda = settle(lk.sda_sy, lk.sda);
        next_lk.abt = settle(lk.abt_sy, lk.abt);
        next_lk.ack = settle(lk.ack_sy, lk.ack);
        scl_rise = next_lk.scl & ~lk.scl;
        scl_fall = ~next_lk.scl & lk.scl;
        // data edges only count while the clock stays high
        start = lk.scl & next_lk.scl & lk.sda & ~next_lk.sda;
        stop = lk.scl & next_lk.scl & ~lk.sda & next_lk.sda;
        rx_byte = {lk.sh[6:0], next_lk.sda};
        buf_hit = lk.tx_valid & (lk.tx_addr == lk.ptr);
        tx_byte = buf_hit ? lk.tx_buf : `RTCIS_IDLE_BYTE;
        do_load = 1'b0;

        // prefetch the byte at the word address so it is ready before the shift
        if (lk.req != lk.ack && next_lk.ack == lk.req) begin
            next_lk.tx_buf = sy.rbyte;
            next_lk.tx_addr = lk.req_addr;
            next_lk.tx_valid = 1'b1;
        end else if (lk.req == lk.ack && !buf_hit) begin
            next_lk.req = ~lk.req;
            next_lk.req_addr = lk.ptr;
        end

        if (next_lk.abt && !lk.abt) begin
            next_lk.state = rtcis_pkg::ST_IDLE;
            next_lk.busy = 1'b0;
            next_lk.oe = 1'b0;
        end else if (start) begin
            next_lk.state = rtcis_pkg::ST_ADDR;
            next_lk.cnt = 3'h0;
            next_lk.busy = 1'b0;
            next_lk.oe = 1'b0;
        end else if (stop) begin
            next_lk.state = rtcis_pkg::ST_IDLE;
            next_lk.busy = 1'b0;
            next_lk.oe = 1'b0;
        end else begin
            case (lk.state)
                rtcis_pkg::ST_ADDR, rtcis_pkg::ST_WRITE: begin
                    if (scl_rise) begin
                        next_lk.sh = rx_byte;
                        next_lk.cnt = lk.cnt + 3'h1;
                        if (lk.cnt == 3'h7) begin
                            next_lk.state = rtcis_pkg::ST_ACK;
                            next_lk.ack_ph = 1'b0;
                            if (lk.state == rtcis_pkg::ST_ADDR) begin
                                if (rx_byte[7:1] == `RTCIS_SLAVE_ADDR) begin
                                    next_lk.do_ack = 1'b1;
                                    next_lk.rw = rx_byte[0];
                                    next_lk.first = 1'b1;
                                    next_lk.busy = 1'b1;
                                end else begin
                                    next_lk.state = rtcis_pkg::ST_IDLE;
                                end
                            end else if (lk.first) begin
                                next_lk.ptr = rx_byte[3:0];
                                next_lk.first = 1'b0;
                                next_lk.do_ack = 1'b1;
                            end else begin
                                // a full buffer answers with no-ack and drops the byte
                                next_lk.do_ack = fifo_ready;
                                if (fifo_ready) begin
                                    next_lk.push = 1'b1;
                                    next_lk.push_data = {lk.ptr, rx_byte};
                                    next_lk.ptr = lk.ptr + 4'h1;
                                end
                            end
                        end
                    end
                end
                rtcis_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!lk.ack_ph) begin
                            next_lk.oe = lk.do_ack;
                            next_lk.ack_ph = 1'b1;
                        end else begin
                            next_lk.oe = 1'b0;
                            next_lk.cnt = 3'h0;
                            if (!lk.do_ack) begin
                                next_lk.state = rtcis_pkg::ST_IDLE;
                            end else if (lk.rw) begin
                                do_load = 1'b1;
                            end else begin
                                next_lk.state = rtcis_pkg::ST_WRITE;
                            end
                        end
                    end
                end
                rtcis_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        if (lk.cnt == 3'h7) begin
                            next_lk.oe = 1'b0;
                            next_lk.state = rtcis_pkg::ST_MACK;
                        end else begin
                            next_lk.oe = ~lk.sh[7];
                            next_lk.sh = {lk.sh[6:0], 1'b0};
                            next_lk.cnt = lk.cnt + 3'h1;
                        end
                    end
                end
                rtcis_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        next_lk.mack = ~next_lk.sda;
                    end
                    if (scl_fall) begin
                        if (lk.mack) begin
                            do_load = 1'b1;
                        end else begin
                            // line stays released so the master can stop
                            next_lk.state = rtcis_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (do_load) begin
            next_lk.state = rtcis_pkg::ST_SEND;
            next_lk.oe = ~tx_byte[7];
            next_lk.sh = {tx_byte[6:0], 1'b0};
            next_lk.cnt = 3'h0;
            next_lk.ptr = lk.ptr + 4'h1;
        end

        if (link_rst) begin
            next_lk = '0;
            next_lk.scl_sy = 3'h7;
            next_lk.sda_sy = 3'h7;
            next_lk.scl = 1'b1;
            next_lk.sda = 1'b1;
            next_lk.state = rtcis_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge link_clk_i) begin
        lk <= next_lk;
    end

    // the device only pulls low and never touches the clock line
    assign sda_o = 1'b0;
    assign sda_oe_o = lk.oe;

    // ----------------------------------------
    // write path into the system domain
    // ----------------------------------------
    rtcis_fifo #(
        .WIDTH(`RTCIS_FIFO_WIDTH),
        .DEPTH(`RTCIS_FIFO_DEPTH)
    ) u_fifo (
        .wclk_i(link_clk_i),
        .wrst_i(link_rst),
        .in_valid_i(lk.push),
        .in_ready_o(fifo_ready),
        .in_data_i(lk.push_data),
        .rclk_i(clock_i),
        .rrst_i(rst_i),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(fifo_out)
    );

    assign wr_addr_o = fifo_out[11:8];
    assign wr_data_o = fifo_out[7:0];

    // ----------------------------------------
    // system domain: read service and watchdog
    // ----------------------------------------
    always_comb begin
        next_sy = sy;
        next_sy.req_sy = {sy.req_sy[1:0], lk.req};
        next_sy.req = settle(sy.req_sy, sy.req);
        next_sy.bsy_sy = {sy.bsy_sy[1:0], lk.busy};
        next_sy.busy = settle(sy.bsy_sy, sy.busy);
        next_sy.strobe = 1'b0;
        next_sy.pulse = 1'b0;
        // request address is held still by the link until the answer returns
        if (sy.strobe) begin
            next_sy.rbyte = rd_data_i;
            next_sy.ack = ~sy.ack;
        end else if (sy.req != sy.ack) begin
            next_sy.strobe = 1'b1;
            next_sy.raddr = lk.req_addr;
        end
        // counts a full second from the address, well inside the two second bound
        if (!next_sy.busy) begin
            next_sy.cnt = '0;
            next_sy.abort = 1'b0;
        end else if (!sy.abort) begin
            if (sy.cnt == CW'(WDOG_CYCLES - 1)) begin
                next_sy.abort = 1'b1;
                next_sy.pulse = 1'b1;
            end else begin
                next_sy.cnt = sy.cnt + 1'b1;
            end
        end
        // frozen for the whole watchdog period, so one second is lost
        next_sy.freeze = next_sy.busy & ~next_sy.abort;
        if (rst_i) begin
            next_sy = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        sy <= next_sy;
    end

    assign rd_strobe_o = sy.strobe;
    assign rd_addr_o = sy.raddr;
    assign freeze_o = sy.freeze;
    assign wdog_abort_o = sy.pulse;
endmodule

// ==== tb/rtcis_checker.sv ====
`timescale 1ns/10ps
// --------
// bus and watchdog checker
// --------
module rtcis_checker #(
    parameter int WDOG_CYCLES = 200
) (
    // clocks
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    // link
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // user side
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire logic [3:0] wr_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic rd_strobe_o,
    input wire logic freeze_o,
    input wire logic wdog_abort_o
);
    // length of the current freeze, in clock_i cycles
    logic [31:0] frz_cnt;
    always_ff @(posedge clock_i) begin
        if (rst_i || !freeze_o) begin
            frz_cnt <= 32'h0;
        end else begin
            frz_cnt <= frz_cnt + 32'h1;
        end
    end
    // a start or stop: data moves while the clock is high
    sequence s_bus_cond;
        scl_i && $changed(sda_i);
    endsequence
    sequence s_ack_drive;
        sda_oe_o [*8];
    endsequence

    a_sda_open_drain: assert property (@(posedge clock_i) disable iff (rst_i) !sda_o)
        else $error("data pin driven high");
    a_oe_clock_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("data changed while clock high");
    a_ack_holds: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(sda_oe_o) |-> s_ack_drive) else $error("data drive too short");
    a_cond_unfreeze: assert property (@(posedge clock_i) disable iff (rst_i)
        s_bus_cond |-> ##[1:60] !freeze_o) else $error("freeze kept after start or stop");
    a_freeze_bound: assert property (@(posedge clock_i) disable iff (rst_i)
        frz_cnt <= WDOG_CYCLES + 1) else $error("freeze outlived watchdog");
    a_abort_timing: assert property (@(posedge clock_i) disable iff (rst_i)
        wdog_abort_o |-> frz_cnt >= WDOG_CYCLES - 8) else $error("watchdog fired early");
    a_abort_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
        wdog_abort_o |-> $past(freeze_o) && !freeze_o ##1 !wdog_abort_o)
        else $error("abort not a single pulse ending freeze");
    a_strobe_spacing: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_strobe_o |=> !rd_strobe_o [*7]) else $error("read strobes too close");
    a_wr_head_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
        else $error("write head changed while waiting");
endmodule

bind rtcis_top rtcis_checker #(.WDOG_CYCLES(WDOG_CYCLES)) rtcis_checker_inst (
    .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o),
    .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .rd_strobe_o(rd_strobe_o), .freeze_o(freeze_o), .wdog_abort_o(wdog_abort_o));

// ==== tb/rtcis_master.sv ====
`timescale 1ns/10ps
// --------
// two-wire bus master model
// --------
module rtcis_master #(
    parameter int Q = 32
) (
    // clock and wire
    input wire logic clock_i,
    input wire logic sda_i,
    // open-drain outputs, 1 means released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wait_q;
        repeat (Q) @(posedge clock_i);
    endtask
    // data moves only in mid-low phase, sampled in mid-high
    task automatic put_bit(input logic b, output logic s);
        sda_o <= b;
        wait_q();
        scl_o <= 1'b1;
        wait_q();
        s = sda_i;
        wait_q();
        scl_o <= 1'b0;
        wait_q();
    endtask
    // also a repeated start; begins only once both lines are high
    task automatic start_cond;
        sda_o <= 1'b1;
        wait_q();
        scl_o <= 1'b1;
        wait_q();
        sda_o <= 1'b0;
        wait_q();
        scl_o <= 1'b0;
        wait_q();
    endtask
    task automatic stop_cond;
        sda_o <= 1'b0;
        wait_q();
        scl_o <= 1'b1;
        wait_q();
        sda_o <= 1'b1;
        wait_q();
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, ack);
    endtask
    // nack high on the last byte, then the caller stops
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(nack, s);
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    localparam int WD = 20000;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic link_clk_i = 1'b0;
    logic scl, sda_m, sda_w, sda_o, sda_oe_o, wr_valid_o, rd_strobe_o;
    logic wr_ready_i = 1'b0;
    logic freeze_o, wdog_abort_o, ack;
    logic [3:0] wr_addr_o, rd_addr_o;
    logic [7:0] wr_data_o, rd_data_i, d;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int n_abort = 0;
    // --------
    // wire, clocks, user register file
    // --------
    assign sda_w = sda_m & ~(sda_oe_o & ~sda_o); // pull-up, wired-and
    assign rd_data_i = {rd_addr_o, ~rd_addr_o};
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    initial begin
        #7;
        forever #80 link_clk_i = ~link_clk_i;
    end
    rtcis_top #(.WDOG_CYCLES(WD)) rtcis_top_inst (
        .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o),
        .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .rd_strobe_o(rd_strobe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
        .freeze_o(freeze_o), .wdog_abort_o(wdog_abort_o));
    rtcis_master #(.Q(32)) rtcis_master_inst (
        .clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    // --------
    // checking and closing
    // --------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (wdog_abort_o === 1'b1) n_abort <= n_abort + 1;
        if (cyc == 90000) begin
            n_errors++;
            summarize();
        end
    end
    // --------
    // scenarios
    // --------
    task automatic test_fifo_fill;
        int k;
        rtcis_master_inst.start_cond();
        rtcis_master_inst.send_byte(8'hA2, ack);
        check(12'(ack), 12'h0);
        rtcis_master_inst.send_byte(8'h3C, ack);
        check(12'(ack), 12'h0);
        check(12'(freeze_o), 12'h1);
        for (int i = 0; i < 9; i++) begin
            rtcis_master_inst.send_byte(8'h40 + 8'(i), ack);
            check(12'(ack), 12'(i == 8));
        end
        rtcis_master_inst.stop_cond();
        repeat (60) @(posedge clock_i);
        check(12'(freeze_o), 12'h0);
        // pop one entry at a time so the head is seen waiting first
        for (int i = 0; i < 8; i++) begin
            k = 0;
            do begin
                @(posedge clock_i);
                #1;
                k++;
            end while (wr_valid_o !== 1'b1 && k < 100);
            check({wr_addr_o, wr_data_o}, {4'hC + 4'(i), 8'h40 + 8'(i)});
            @(posedge clock_i);
            wr_ready_i <= 1'b1;
            @(posedge clock_i);
            wr_ready_i <= 1'b0;
        end
        repeat (20) @(posedge clock_i);
        check(12'(wr_valid_o), 12'h0);
    endtask
    task automatic test_bad_addr;
        logic [7:0] bad [2] = '{8'hA4, 8'h23};
        for (int i = 0; i < 2; i++) begin
            rtcis_master_inst.start_cond();
            rtcis_master_inst.send_byte(bad[i], ack);
            check(12'(ack), 12'h1);
            rtcis_master_inst.send_byte(8'h00, ack);
            check({ack, 3'h0, freeze_o}, 5'h10);
            rtcis_master_inst.stop_cond();
        end
    endtask
    task automatic test_read;
        logic [7:0] exp [3] = '{8'hE1, 8'hF0, 8'h0F};
        rtcis_master_inst.start_cond();
        rtcis_master_inst.send_byte(8'hA2, ack);
        rtcis_master_inst.send_byte(8'hFE, ack);
        rtcis_master_inst.start_cond();
        rtcis_master_inst.send_byte(8'hA3, ack);
        check(12'(ack), 12'h0);
        for (int i = 0; i < 3; i++) begin
            rtcis_master_inst.recv_byte(i == 2, d);
            check(12'(d), 12'(exp[i]));
        end
        check({freeze_o, sda_oe_o, sda_w}, 3'h5);
        rtcis_master_inst.stop_cond();
    endtask
    task automatic test_watchdog;
        int n0;
        int k;
        n0 = n_abort;
        rtcis_master_inst.start_cond();
        rtcis_master_inst.send_byte(8'hA2, ack);
        repeat (15000) @(posedge clock_i);
        check(12'(freeze_o), 12'h1);
        rtcis_master_inst.start_cond();
        rtcis_master_inst.send_byte(8'hA2, ack);
        check(12'(n_abort - n0), 12'h0);
        k = 0;
        while (n_abort == n0 && k < 2 * WD) begin
            @(posedge clock_i);
            k++;
        end
        check(12'(k > WD - 300 && k <= WD), 12'h1);
        repeat (40) @(posedge clock_i);
        check({freeze_o, sda_oe_o, 10'(n_abort - n0)}, 12'h1);
        rtcis_master_inst.stop_cond();
        rtcis_master_inst.start_cond();
        rtcis_master_inst.send_byte(8'hA2, ack);
        check(12'(ack), 12'h0);
        rtcis_master_inst.stop_cond();
    endtask
    // reset spans enough link cycles for the link side to leave it too
    initial begin
        repeat (36) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (40) @(posedge clock_i);
        test_fifo_fill();
        test_bad_addr();
        test_read();
        test_watchdog();
        summarize();
    end
endmodule
